// ---- uart_xcvr.sv ----
// serial transceiver: double-buffered transmit with status flags and
// a receiver with error status and overrun detection
// assumes rxd comes from a pin; all control is plain ports on clk
module uart_xcvr #(
    parameter int DIV = uart_cfg_pkg::DIV_DEFAULT  // clocks per bit
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       tx_enable,           // transmit unit on
    input  wire logic       rx_enable,           // receive unit on
    input  wire logic       parity_select_hi,    // parity mode bit 1
    input  wire logic       parity_select_lo,    // parity mode bit 0
    input  wire logic       two_stop,            // transmit two stop bits
    input  wire logic       tx_write,            // pulse: write holding buffer
    input  wire logic [7:0] tx_wdata,            // byte written
    output logic            tx_buffer_full_flag, // holding buffer occupied
    output logic            tx_shift_busy_flag,  // shifter sending
    output logic [7:0]      tx_status_register,  // {0,..,full,busy}
    output logic            tx_complete_interrupt, // pulse per sent frame
    output logic            txd,                 // serial out
    input  wire logic       rxd,                 // serial in, asynchronous
    input  wire logic       rx_status_read,      // pulse: error status read
    input  wire logic       rx_data_read,        // pulse: receive buffer read
    output logic [7:0]      rx_holding_buffer,   // received byte
    output logic [2:0]      rx_error_status_register, // parity, frame, overrun
    output logic            rx_complete          // pulse per received frame
);
    localparam int CW = $clog2(DIV);

    ///////////////////////////////////////////////////////////////////////
    // baud divider: one-cycle tick for transmit
    logic [CW-1:0] tx_div;           // transmit bit timer
    wire           tx_tick = tx_enable && (tx_div == CW'(DIV - 1));
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) tx_div <= '0;
        else if (!tx_enable || tx_tick) tx_div <= '0;
        else tx_div <= tx_div + CW'(1);
    end

    wire [1:0] parity_sel = {parity_select_hi, parity_select_lo};

    ///////////////////////////////////////////////////////////////////////
    // transmit holding buffer
    tx_shift_if sh ();
    logic [7:0] hold;                // byte waiting for the shifter
    // idle shifter and full buffer: hand over this cycle
    wire        do_load = tx_buffer_full_flag && !sh.busy && tx_enable;
    assign sh.load = do_load;
    assign sh.data = hold;

    // [R12] load on idle
    // [R1] full then busy, full clearing in the cycle busy sets
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_buffer_full_flag <= 1'b0;
            hold                <= uart_cfg_pkg::DATA_RESET;
        end else if (!tx_enable) begin
            tx_buffer_full_flag <= 1'b0;
        end else if (tx_write) begin
            // a write while full overwrites: data not guaranteed
            tx_buffer_full_flag <= 1'b1;
            hold                <= tx_wdata;
        end else if (do_load) begin
            tx_buffer_full_flag <= 1'b0;
        end
    end

    uart_tx_shifter u_shift (
        .clk        (clk),
        .rstn       (rstn),
        .bit_tick   (tx_tick),
        .parity_sel (parity_sel),
        .two_stop   (two_stop),
        .port       (sh.shift),
        .txd        (txd)
    );

    // [R6] completion per frame
    assign tx_shift_busy_flag    = sh.busy;
    assign tx_complete_interrupt = sh.done;
    assign tx_status_register    = {6'h00, tx_buffer_full_flag, tx_shift_busy_flag};

    // [R12] check shifter takes byte
    chk_load_sets_busy: assert property (@(posedge clk) disable iff (!rstn) // [R12]
        do_load |=> tx_shift_busy_flag && !tx_buffer_full_flag)
        else $error("load did not move byte into shifter");
    // [R1] check flag sequence
    chk_full_busy_order: assert property (@(posedge clk) disable iff (!rstn) // [R1]
        (tx_buffer_full_flag && !tx_shift_busy_flag && !tx_write) |=>
        (!tx_buffer_full_flag && tx_shift_busy_flag) || !tx_enable)
        else $error("full flag did not hand over to busy");
    // [R6] check completion timing
    chk_done_ends_busy: assert property (@(posedge clk) disable iff (!rstn) // [R6]
        tx_complete_interrupt && !tx_buffer_full_flag |=> !tx_shift_busy_flag)
        else $error("busy stayed after frame completion");

    ///////////////////////////////////////////////////////////////////////
    // receive input synchroniser
    logic rxd_meta;                  // first stage, read only by rxd_sync
    logic rxd_sync;                  // safe copy of the line
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxd_meta <= 1'b1;
            rxd_sync <= 1'b1;
        end else begin
            rxd_meta <= rxd;
            rxd_sync <= rxd_meta;
        end
    end

    ///////////////////////////////////////////////////////////////////////
    // receiver: samples mid-bit, one stop bit only
    uart_cfg_pkg::rx_state_t rx_state; // frame phase
    logic [CW-1:0] rx_div;           // bit timer, restarted on start edge
    logic [2:0]    rx_cnt;           // data bit index
    logic [7:0]    rx_shreg;         // bits collected
    logic          rx_par;           // running parity of data
    logic          rx_full;          // holding buffer not yet read
    wire           rx_mid   = (rx_div == CW'(DIV / 2));
    wire           rx_end   = (rx_div == CW'(DIV - 1));
    wire           rx_par_ok = (parity_sel == uart_cfg_pkg::PAR_ODD)  ? (rx_par ^ rxd_sync) :
                               (parity_sel == uart_cfg_pkg::PAR_EVEN) ? !(rx_par ^ rxd_sync) :
                               (parity_sel == uart_cfg_pkg::PAR_ZERO) ? 1'b1 : 1'b1;
    // stop sampled: frame finishes here, a second stop bit never looked at
    wire           stop_hit = rx_mid && (rx_state == uart_cfg_pkg::RX_STOP);
    logic          par_err;          // parity error of frame in flight
    assign rx_complete = stop_hit;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) rx_div <= '0;
        else if (rx_state == uart_cfg_pkg::RX_IDLE || rx_end) rx_div <= '0;
        else rx_div <= rx_div + CW'(1);
    end

    // [R9] single stop bit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_state <= uart_cfg_pkg::RX_IDLE;
            rx_cnt   <= 3'h0;
            rx_shreg <= uart_cfg_pkg::DATA_RESET;
            rx_par   <= 1'b0;
            par_err  <= 1'b0;
        end else if (!rx_enable) begin
            rx_state <= uart_cfg_pkg::RX_IDLE;
        end else begin
            case (rx_state)
                uart_cfg_pkg::RX_IDLE: begin
                    if (!rxd_sync) rx_state <= uart_cfg_pkg::RX_START;
                end
                uart_cfg_pkg::RX_START: begin
                    // a start bit gone high by mid-bit was a glitch
                    if (rx_mid && rxd_sync) rx_state <= uart_cfg_pkg::RX_IDLE;
                    else if (rx_end) begin
                        rx_state <= uart_cfg_pkg::RX_DATA;
                        rx_cnt   <= 3'h0;
                        rx_par   <= 1'b0;
                        par_err  <= 1'b0;
                    end
                end
                uart_cfg_pkg::RX_DATA: begin
                    if (rx_mid) begin
                        rx_shreg <= {rxd_sync, rx_shreg[7:1]};
                        rx_par   <= rx_par ^ rxd_sync;
                    end
                    if (rx_end) begin
                        rx_cnt <= rx_cnt + 3'h1;
                        if (rx_cnt == 3'h7) begin
                            rx_state <= (parity_sel == uart_cfg_pkg::PAR_NONE) ?
                                        uart_cfg_pkg::RX_STOP : uart_cfg_pkg::RX_PARITY;
                        end
                    end
                end
                uart_cfg_pkg::RX_PARITY: begin
                    if (rx_mid) par_err <= !rx_par_ok;
                    if (rx_end) rx_state <= uart_cfg_pkg::RX_STOP;
                end
                uart_cfg_pkg::RX_STOP: begin
                    if (rx_mid) rx_state <= uart_cfg_pkg::RX_IDLE;
                end
                default: rx_state <= uart_cfg_pkg::RX_IDLE;
            endcase
        end
    end

    ///////////////////////////////////////////////////////////////////////
    // receive buffer and error status; new errors win over a clear
    // [R8] overrun on unread
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_holding_buffer        <= uart_cfg_pkg::DATA_RESET;
            rx_full                  <= 1'b0;
            rx_error_status_register <= 3'h0;
        end else if (stop_hit) begin
            rx_holding_buffer <= rx_shreg;
            rx_full           <= 1'b1;
            rx_error_status_register[uart_cfg_pkg::ERR_OVERRUN] <=
                rx_full || (rx_error_status_register[uart_cfg_pkg::ERR_OVERRUN]
                            && !rx_status_read);
            rx_error_status_register[uart_cfg_pkg::ERR_FRAME] <= !rxd_sync ||
                (rx_error_status_register[uart_cfg_pkg::ERR_FRAME] && !rx_status_read);
            rx_error_status_register[uart_cfg_pkg::ERR_PARITY] <= par_err ||
                (rx_error_status_register[uart_cfg_pkg::ERR_PARITY] && !rx_status_read);
        end else begin
            if (rx_data_read) rx_full <= 1'b0;
            if (rx_status_read) rx_error_status_register <= 3'h0;
        end
    end

    // [R8] check overrun flagged
    chk_overrun_flag: assert property (@(posedge clk) disable iff (!rstn) // [R8]
        (stop_hit && rx_full) |=> rx_error_status_register[uart_cfg_pkg::ERR_OVERRUN])
        else $error("unread byte overwritten without overrun");
    // [R9] check single stop
    chk_one_stop: assert property (@(posedge clk) disable iff (!rstn) // [R9]
        stop_hit |=> rx_state == uart_cfg_pkg::RX_IDLE)
        else $error("receiver waited beyond one stop bit");
    // [R9] check framing follows line
    chk_frame_err: assert property (@(posedge clk) disable iff (!rstn) // [R9]
        (stop_hit && !rxd_sync) |=> rx_error_status_register[uart_cfg_pkg::ERR_FRAME])
        else $error("low stop bit not flagged");
    // [R8] check data captured
    chk_rx_capture: assert property (@(posedge clk) disable iff (!rstn) // [R8]
        stop_hit |=> rx_full && rx_holding_buffer == $past(rx_shreg))
        else $error("received byte not captured");
    // [R1] check no buffer loss
    chk_write_sets_full: assert property (@(posedge clk) disable iff (!rstn) // [R1]
        (tx_write && tx_enable) |=> tx_buffer_full_flag)
        else $error("write did not set buffer-full");
endmodule

// ---- uart_cfg_pkg.sv ----
// constants shared by the serial transceiver and its shift engine
// assumes one 100 MHz clock and an active-low asynchronous reset
// How it works
// [R1] buffer/shift flags step 10, 11, 01; a load here goes from 10 straight to 01
// [R2] software judges only the buffer-full flag
// [R3] on LIN, wait for status zero
// [R4] write holding buffer only when not full
// [R5] reinitialize only after shift-busy clears
// [R6] completion pulse per frame, software detects overrun
// [R7] software reads every received byte
// [R8] unread byte on new frame flags overrun
// [R9] receiver checks exactly one stop bit
// [R10] software reads error status before data
// [R11] parity select held zero on LIN
// [R12] idle shifter loads holding buffer at once
package uart_cfg_pkg;
    localparam int          CLK_HZ       = 100_000_000; // system clock rate
    localparam int          BAUD_DEFAULT = 115_200;     // plain default rate
    localparam int          DIV_DEFAULT  = CLK_HZ / BAUD_DEFAULT; // clocks per bit
    localparam logic [7:0]  DATA_RESET   = 8'h00;       // data registers after reset
    localparam logic [1:0]  PAR_NONE     = 2'h0;        // parity select: none
    localparam logic [1:0]  PAR_ZERO     = 2'h1;        // parity select: always zero
    localparam logic [1:0]  PAR_ODD      = 2'h2;        // parity select: odd
    localparam logic [1:0]  PAR_EVEN     = 2'h3;        // parity select: even
    localparam int          ERR_PARITY   = 2;           // error status bit positions
    localparam int          ERR_FRAME    = 1;
    localparam int          ERR_OVERRUN  = 0;
    // transmit shifter states, gray along start-data-parity-stop
    typedef enum logic [2:0] {
        TX_IDLE   = 3'h0,
        TX_START  = 3'h1,
        TX_DATA   = 3'h3,
        TX_PARITY = 3'h2,
        TX_STOP   = 3'h6
    } tx_state_t;
    // receive states, gray along start-data-parity-stop
    typedef enum logic [2:0] {
        RX_IDLE   = 3'h0,
        RX_START  = 3'h1,
        RX_DATA   = 3'h3,
        RX_PARITY = 3'h2,
        RX_STOP   = 3'h6
    } rx_state_t;
endpackage

// ---- tx_shift_if.sv ----
// carrier between the transceiver top and its transmit shifter
// assumes both ends sit on the same clock
interface tx_shift_if;
    logic       load;   // one-cycle pulse: take byte into shifter
    logic [7:0] data;   // byte to shift out
    logic       busy;   // shifter holds a frame
    logic       done;   // one-cycle pulse at the tick that starts the last stop bit
    modport ctrl  (output load, output data, input busy, input done);
    modport shift (input load, input data, output busy, output done);
endinterface

// ---- uart_tx_shifter.sv ----
// transmit shifter: start bit, eight data bits lsb first, parity, stop bits
// assumes bit_tick is a one-cycle enable at the baud rate
module uart_tx_shifter (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       bit_tick,   // one pulse per bit time
    input  wire logic [1:0] parity_sel, // parity mode
    input  wire logic       two_stop,   // send a second stop bit
    tx_shift_if.shift       port,
    output logic            txd         // serial output, idle high
);
    uart_cfg_pkg::tx_state_t state;     // frame phase
    logic [7:0]              shreg;     // bits still to send
    logic [2:0]              bit_cnt;   // data bit index
    logic                    par;       // running odd/even sum
    logic                    stop2;     // second stop bit pending

    // parity bit to send for the selected mode
    wire par_bit = (parity_sel == uart_cfg_pkg::PAR_ODD)  ? ~par :
                   (parity_sel == uart_cfg_pkg::PAR_EVEN) ? par  : 1'b0;
    assign port.busy = (state != uart_cfg_pkg::TX_IDLE);
    assign port.done = bit_tick && (state == uart_cfg_pkg::TX_STOP) && !stop2;

    ///////////////////////////////////////////////////////////////////////
    // frame sequencer; a load only arrives while idle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state   <= uart_cfg_pkg::TX_IDLE;
            shreg   <= uart_cfg_pkg::DATA_RESET;
            bit_cnt <= 3'h0;
            par     <= 1'b0;
            stop2   <= 1'b0;
            txd     <= 1'b1;
        end else if (port.load) begin
            state <= uart_cfg_pkg::TX_START;
            shreg <= port.data;
            par   <= 1'b0;
            stop2 <= two_stop;
        end else if (bit_tick) begin
            case (state)
                uart_cfg_pkg::TX_START: begin
                    txd     <= 1'b0;
                    bit_cnt <= 3'h0;
                    state   <= uart_cfg_pkg::TX_DATA;
                end
                uart_cfg_pkg::TX_DATA: begin
                    txd     <= shreg[0];
                    par     <= par ^ shreg[0];
                    shreg   <= {1'b0, shreg[7:1]};
                    bit_cnt <= bit_cnt + 3'h1;
                    if (bit_cnt == 3'h7) begin
                        state <= (parity_sel == uart_cfg_pkg::PAR_NONE) ?
                                 uart_cfg_pkg::TX_STOP : uart_cfg_pkg::TX_PARITY;
                    end
                end
                uart_cfg_pkg::TX_PARITY: begin
                    txd   <= par_bit;
                    state <= uart_cfg_pkg::TX_STOP;
                end
                uart_cfg_pkg::TX_STOP: begin
                    // this tick raises the line; a following start waits one more bit
                    txd <= 1'b1;
                    if (stop2) begin
                        stop2 <= 1'b0;
                    end else begin
                        state <= uart_cfg_pkg::TX_IDLE;
                    end
                end
                default: begin
                    txd   <= 1'b1;
                    state <= uart_cfg_pkg::TX_IDLE;
                end
            endcase
        end
    end
endmodule

// ---- remote_node.sv ----
// remote serial node: sends frames on rxd and decodes frames seen on txd
// assumes the transceiver's clock, DIV clocks per bit, no parity on txd
module remote_node #(
    parameter int DIV = 8  // clocks per bit
) (
    input  wire logic clk,
    input  wire logic txd,
    output logic      rxd
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] got[$];  // bytes decoded from txd, oldest first
    logic [7:0] shreg;   // decode shift register

    // line idles high, as with a pull-up
    initial rxd = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // one bit time on rxd, changed just after an edge
    task automatic put_bit(input logic v);
        rxd = v;
        repeat (DIV) @(posedge clk);
        #1;
    endtask

    // one frame out, lsb first; stop_lvl low forges a framing fault
    task automatic send(input logic [7:0] b, input int n_stop, input logic stop_lvl);
        int i;
        @(posedge clk);
        #1;
        put_bit(1'b0);
        for (i = 0; i < 8; i++) begin
            put_bit(b[i]);
        end
        put_bit(stop_lvl);
        for (i = 1; i < n_stop; i++) begin
            put_bit(1'b1);
        end
        rxd = 1'b1;
    endtask

    // one frame with a parity bit of the caller's choosing and one stop bit
    task automatic send_par(input logic [7:0] b, input logic p);
        @(posedge clk);
        #1;
        put_bit(1'b0);
        for (int i = 0; i < 8; i++) begin
            put_bit(b[i]);
        end
        put_bit(p);
        put_bit(1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // decoder: sample mid-bit so the sample never lands on a txd change
    always begin
        @(negedge txd);
        repeat (DIV / 2) @(posedge clk);
        for (int k = 0; k < 8; k++) begin
            repeat (DIV) @(posedge clk);
            shreg = {txd, shreg[7:1]};
        end
        repeat (DIV) @(posedge clk);
        got.push_back(shreg);
    end
endmodule

// ---- testbench.sv ----
// self-checking bench for the serial transceiver
// assumes uart_xcvr with DIV shortened to 8 and a remote node on the line
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int DIV = 8;  // shortened bit time
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       tx_enable = 1'b0, rx_enable = 1'b0, two_stop = 1'b1;
    logic       par_hi = 1'b0, par_lo = 1'b0;  // parity off, as on a LIN bus
    logic       tx_write = 1'b0, rx_status_read = 1'b0, rx_data_read = 1'b0;
    logic [7:0] tx_wdata = 8'h00;
    logic       full, busy, irq, txd, rxd, rx_done;
    logic [7:0] status, rx_buf;
    logic [2:0] rx_err;
    int         n_fail = 0, num_checks = 0, n_irq = 0;

    uart_xcvr #(.DIV(DIV)) uut (
        .clk(clk), .rstn(rstn), .tx_enable(tx_enable), .rx_enable(rx_enable),
        .parity_select_hi(par_hi), .parity_select_lo(par_lo), .two_stop(two_stop),
        .tx_write(tx_write), .tx_wdata(tx_wdata), .tx_buffer_full_flag(full),
        .tx_shift_busy_flag(busy), .tx_status_register(status),
        .tx_complete_interrupt(irq), .txd(txd), .rxd(rxd),
        .rx_status_read(rx_status_read), .rx_data_read(rx_data_read),
        .rx_holding_buffer(rx_buf), .rx_error_status_register(rx_err),
        .rx_complete(rx_done)
    );
    remote_node #(.DIV(DIV)) remote (.clk(clk), .txd(txd), .rxd(rxd));

    // 100 MHz clock
    always #5 clk = ~clk;

    // count completion pulses as software would see them
    always @(posedge clk) begin
        if (irq === 1'b1) n_irq++;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // bounded wait, sampled just after each edge; running out ends the run
    task automatic wait_lvl(ref logic s, input logic v, input int lim);
        int i;
        for (i = 0; i < lim && s !== v; i++) begin
            @(posedge clk);
            #1;
        end
        if (s !== v) begin
            n_fail++;
            print_verdict();
        end
    endtask

    task automatic write_tx(input logic [7:0] b);
        tx_wdata = b;
        tx_write = 1'b1;
        @(posedge clk);
        #1;
        tx_write = 1'b0;
    endtask

    // error status first, then the data, each read a one-cycle pulse
    task automatic read_rx(input logic [2:0] exp_err, input logic [7:0] exp_d, input bit chk_d);
        check({5'h00, rx_err}, {5'h00, exp_err});
        rx_status_read = 1'b1;
        @(posedge clk);
        #1;
        rx_status_read = 1'b0;
        if (chk_d) check(rx_buf, exp_d);
        rx_data_read = 1'b1;
        @(posedge clk);
        #1;
        rx_data_read = 1'b0;
    endtask

    // wait for one frame to land: the buffer updates the edge after the pulse
    task automatic land();
        wait_lvl(rx_done, 1'b1, 20 * DIV);
        @(posedge clk);
        #1;
    endtask

    task automatic rx_one(input logic [7:0] b, input logic stop_lvl, input logic [2:0] exp_err);
        fork
            remote.send(b, 2, stop_lvl);
            land();
        join
        read_rx(exp_err, b, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        #1;
        rstn = 1'b1;
        rx_enable = 1'b1;
        // writes with the transmit unit off are ignored
        write_tx(8'h5A);
        check(status, 8'h00);
        // let the write strobe be seen low before the next write raises it
        @(posedge clk);
        #1;
        tx_enable = 1'b1;
        // flags step 10, 01, 11, 01
        write_tx(8'hA5);
        check(status, 8'h02);
        @(posedge clk);
        #1;
        check(status, 8'h01);
        // second byte only once the buffer reads empty
        write_tx(8'h3C);
        check(status, 8'h03);
        wait_lvl(full, 1'b0, 20 * DIV);  // judge by full flag only
        check(status, 8'h01);
        // one completion per frame, then shifter idle
        wait_lvl(busy, 1'b0, 40 * DIV);
        check(8'(n_irq), 8'h02);
        check(status, 8'h00);
        check(8'(remote.got.size()), 8'h02);
        if (remote.got.size() == 2) begin
            check(remote.got[0], 8'hA5);
            check(remote.got[1], 8'h3C);
        end
        tx_enable = 1'b0;  // reinitialize only once idle
        // plain frame, then a framing fault
        rx_one(8'h96, 1'b1, 3'h0);
        rx_one(8'h0F, 1'b0, 3'h2);
        // second frame while the first is unread
        fork
            remote.send(8'h11, 1, 1'b1);
            land();
        join
        fork
            remote.send(8'h22, 1, 1'b1);
            land();
        join
        read_rx(3'h1, 8'h00, 1'b0);
        rx_one(8'h44, 1'b1, 3'h0);
        // back-to-back frames with a single stop bit each
        fork
            begin
                remote.send(8'hC3, 1, 1'b1);
                remote.send(8'h3C, 1, 1'b1);
            end
            begin
                land();
                read_rx(3'h0, 8'hC3, 1'b1);
                land();
                read_rx(3'h0, 8'h3C, 1'b1);
            end
        join
        // plain link, not LIN: even parity, a good bit and then a wrong one
        par_hi = 1'b1;
        par_lo = 1'b1;
        fork
            remote.send_par(8'h5A, 1'b0);
            land();
        join
        read_rx(3'h0, 8'h5A, 1'b1);
        fork
            remote.send_par(8'h5A, 1'b1);
            land();
        join
        read_rx(3'h4, 8'h5A, 1'b1);
        print_verdict();
    end
endmodule
